// file: design/hpsi_pkg.sv
package hpsi_pkg;
  localparam int NUM_PORTS = 6;
  localparam int HOST_BITS = 2;
  localparam logic LVL_LOW = 1'h0;
  localparam logic LVL_HIGH = 1'h1;
  localparam logic OE_DRIVE = 1'h0;
  localparam logic OE_FLOAT = 1'h1;
  // strap sync takes two edges after power-on release, sample on the third
  localparam logic [1:0] POR_CNT_RST = 2'h0;
  localparam logic [1:0] POR_SAMPLE_AT = 2'h2;
  localparam logic [1:0] POR_DONE = 2'h3;
  localparam logic [1:0] POR_STEP = 2'h1;

  typedef enum logic {HPSI_ROLE_TARGET, HPSI_ROLE_BRIDGE} hpsi_role_t;

  typedef struct packed {
    logic attached;
    logic super_speed;
    logic bc_enabled;
    logic bc_done;
  } hpsi_port_t;

  typedef struct packed {
    logic connected;
    logic super_speed;
  } hpsi_host_t;

  typedef struct packed {
    logic val;
    logic oe_n;
  } hpsi_tri_t;

  typedef struct packed {
    logic scl_low;
    logic sda_low;
  } hpsi_wire_req_t;

  localparam hpsi_tri_t TRI_FLOAT = '{val: LVL_LOW, oe_n: OE_FLOAT};

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic rst_prev;
    logic strap_s1;
    logic strap_s2;
    logic scl_s1;
    logic scl_s2;
    logic sda_s1;
    logic sda_s2;
    logic [1:0] por_cnt;
    hpsi_role_t role;
    logic in_reset;
    hpsi_tri_t [NUM_PORTS-1:0] spd;
    hpsi_tri_t [NUM_PORTS-1:0] bc;
    hpsi_tri_t [HOST_BITS-1:0] host;
    logic susp;
    logic scl_oe_n;
    logic sda_oe_n;
  } hpsi_state_t;

  localparam hpsi_state_t STATE_RST = '{
    rst_s1: LVL_LOW, rst_s2: LVL_LOW, rst_prev: LVL_LOW,
    strap_s1: LVL_LOW, strap_s2: LVL_LOW,
    scl_s1: LVL_HIGH, scl_s2: LVL_HIGH, sda_s1: LVL_HIGH, sda_s2: LVL_HIGH,
    por_cnt: POR_CNT_RST, role: HPSI_ROLE_TARGET, in_reset: LVL_HIGH,
    spd: '{default: TRI_FLOAT}, bc: '{default: TRI_FLOAT},
    host: '{default: TRI_FLOAT}, susp: LVL_LOW,
    scl_oe_n: OE_FLOAT, sda_oe_n: OE_FLOAT
  };
endpackage : hpsi_pkg

// file: design/hpsi_top.sv
// Notes on behaviour
// R1: port speed: float none, low 2.0, high 3.1
// R2: charge: float off, low done, high pending
// R3: host speed: float none, low 3.1, high 2.0
// R4: suspend output follows USB 2.0 suspend state, held low in reset
// R5: held in reset mode while reset pin low
// R6: two-wire pins act as target or bridge
// R7: straps latched at power-on and reset release
// R8: indicators float in reset, update quickly after
module hpsi_top (
  input wire logic i_clk_sys, // 10 MHz system clock
  input wire logic i_nrst, // power-on reset, async, active low
  input wire logic i_rst_pin_n, // external reset pin, active low
  input wire logic i_cfg_strap, // device mode strap pin, 1 selects bridge
  input hpsi_pkg::hpsi_port_t [5:0] i_port, // downstream port state from core
  input hpsi_pkg::hpsi_host_t i_host, // host port state from core
  input wire logic i_suspended, // hub is in USB 2.0 suspend
  input hpsi_pkg::hpsi_wire_req_t i_tgt_req, // target engine wants wire low
  input hpsi_pkg::hpsi_wire_req_t i_brg_req, // bridge master wants wire low
  input wire logic i_mgmt_bus_clock_pin, // clock wire level
  input wire logic i_mgmt_bus_data_pin, // data wire level
  output logic [5:0] o_port_speed_indicator, // speed level per port
  output logic [5:0] o_port_speed_indicator_oe_n, // low while driven
  output logic [5:0] o_charge_handshake_indicator, // charge level per port
  output logic [5:0] o_charge_handshake_indicator_oe_n, // low while driven
  output logic [1:0] o_host_speed_indicator, // host speed level
  output logic [1:0] o_host_speed_indicator_oe_n, // low while driven
  output logic o_suspend_state_output, // high while suspended and not in reset mode
  output logic o_mgmt_bus_clock_pin, // clock wire drive value
  output logic o_mgmt_bus_clock_pin_oe_n, // low while pulling clock low
  output logic o_mgmt_bus_data_pin, // data wire drive value
  output logic o_mgmt_bus_data_pin_oe_n, // low while pulling data low
  output logic o_mgmt_scl_sync, // synchronised clock wire level
  output logic o_mgmt_sda_sync, // synchronised data wire level
  output logic o_role_bridge, // latched role, 1 for bridge master
  output logic o_reset_mode // hub held in reset mode
);

  hpsi_pkg::hpsi_state_t s;
  hpsi_pkg::hpsi_state_t next_s;
  logic rst_rise;
  logic por_sample;
  hpsi_pkg::hpsi_wire_req_t req;

  function automatic hpsi_pkg::hpsi_tri_t drive(input logic lvl);
    hpsi_pkg::hpsi_tri_t t;
    t.val = lvl;
    t.oe_n = hpsi_pkg::OE_DRIVE;
    return t;
  endfunction : drive

  function automatic hpsi_pkg::hpsi_tri_t spd_decode(input logic rst_mode,
                                                      input hpsi_pkg::hpsi_port_t p);
    hpsi_pkg::hpsi_tri_t t;
    t = hpsi_pkg::TRI_FLOAT;
    if (!rst_mode && p.attached)
    begin
      t = drive(p.super_speed ? hpsi_pkg::LVL_HIGH : hpsi_pkg::LVL_LOW);
    end
    return t;
  endfunction : spd_decode

  function automatic hpsi_pkg::hpsi_tri_t bc_decode(input logic rst_mode,
                                                     input hpsi_pkg::hpsi_port_t p);
    hpsi_pkg::hpsi_tri_t t;
    t = hpsi_pkg::TRI_FLOAT;
    if (!rst_mode && p.bc_enabled)
    begin
      t = drive(p.bc_done ? hpsi_pkg::LVL_LOW : hpsi_pkg::LVL_HIGH);
    end
    return t;
  endfunction : bc_decode

  always_comb
  begin
    next_s = s;
    next_s.rst_s1 = i_rst_pin_n;
    next_s.rst_s2 = s.rst_s1;
    next_s.rst_prev = s.rst_s2;
    next_s.strap_s1 = i_cfg_strap;
    next_s.strap_s2 = s.strap_s1;
    next_s.scl_s1 = i_mgmt_bus_clock_pin;
    next_s.scl_s2 = s.scl_s1;
    next_s.sda_s1 = i_mgmt_bus_data_pin;
    next_s.sda_s2 = s.sda_s1;
    // R5: reset mode tracks pin
    next_s.in_reset = !s.rst_s2;
    if (s.por_cnt != hpsi_pkg::POR_DONE)
    begin
      next_s.por_cnt = 2'(s.por_cnt + hpsi_pkg::POR_STEP);
    end
    rst_rise = s.rst_s2 && !s.rst_prev;
    por_sample = (s.por_cnt == hpsi_pkg::POR_SAMPLE_AT);
    // R7: latch strap on events
    if (rst_rise || por_sample)
    begin
      next_s.role = s.strap_s2 ? hpsi_pkg::HPSI_ROLE_BRIDGE : hpsi_pkg::HPSI_ROLE_TARGET;
    end
    // R1: per-port speed decode
    // R2: per-port charge decode
    // R8: float while in reset
    for (int i = 0; i < hpsi_pkg::NUM_PORTS; i++)
    begin
      next_s.spd[i] = spd_decode(!s.rst_s2, i_port[i]);
      next_s.bc[i] = bc_decode(!s.rst_s2, i_port[i]);
    end
    // R3: host polarity inverted
    for (int h = 0; h < hpsi_pkg::HOST_BITS; h++)
    begin
      next_s.host[h] = hpsi_pkg::TRI_FLOAT;
      if (s.rst_s2 && i_host.connected)
      begin
        next_s.host[h] = drive(i_host.super_speed ? hpsi_pkg::LVL_LOW : hpsi_pkg::LVL_HIGH);
      end
    end
    // R4: suspend follows core state, low in reset
    next_s.susp = s.rst_s2 && i_suspended;
    // R6: role picks wire driver
    req = (s.role == hpsi_pkg::HPSI_ROLE_BRIDGE) ? i_brg_req : i_tgt_req;
    // wires are released in reset so a stuck engine cannot hang the bus
    next_s.scl_oe_n = (s.rst_s2 && req.scl_low) ? hpsi_pkg::OE_DRIVE : hpsi_pkg::OE_FLOAT;
    next_s.sda_oe_n = (s.rst_s2 && req.sda_low) ? hpsi_pkg::OE_DRIVE : hpsi_pkg::OE_FLOAT;
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      s <= hpsi_pkg::STATE_RST;
    end
    else
    begin
      s <= next_s;
    end
  end

  for (genvar g = 0; g < hpsi_pkg::NUM_PORTS; g++)
  begin : g_port
    assign o_port_speed_indicator[g] = s.spd[g].val;
    assign o_port_speed_indicator_oe_n[g] = s.spd[g].oe_n;
    assign o_charge_handshake_indicator[g] = s.bc[g].val;
    assign o_charge_handshake_indicator_oe_n[g] = s.bc[g].oe_n;
  end

  for (genvar g = 0; g < hpsi_pkg::HOST_BITS; g++)
  begin : g_host
    assign o_host_speed_indicator[g] = s.host[g].val;
    assign o_host_speed_indicator_oe_n[g] = s.host[g].oe_n;
  end

  assign o_suspend_state_output = s.susp;
  // open-drain: only ever pull low
  assign o_mgmt_bus_clock_pin = hpsi_pkg::LVL_LOW;
  assign o_mgmt_bus_data_pin = hpsi_pkg::LVL_LOW;
  assign o_mgmt_bus_clock_pin_oe_n = s.scl_oe_n;
  assign o_mgmt_bus_data_pin_oe_n = s.sda_oe_n;
  assign o_mgmt_scl_sync = s.scl_s2;
  assign o_mgmt_sda_sync = s.sda_s2;
  assign o_role_bridge = (s.role == hpsi_pkg::HPSI_ROLE_BRIDGE);
  assign o_reset_mode = s.in_reset;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);

  sequence pin_low_seq;
    !i_rst_pin_n [*3];
  endsequence

  sequence pin_release_seq;
    s.rst_s2 && !s.rst_prev;
  endsequence

  for (genvar g = 0; g < hpsi_pkg::NUM_PORTS; g++)
  begin : g_chk
    a_spd_float_idle: assert property ( // R1
      (s.rst_s2 && !i_port[g].attached) |=> o_port_speed_indicator_oe_n[g])
      else $error("speed indicator driven with no device attached");
    a_spd_level_drive: assert property ( // R1
      (s.rst_s2 && i_port[g].attached) |=>
        (!o_port_speed_indicator_oe_n[g]
         && o_port_speed_indicator[g] == $past(i_port[g].super_speed)))
      else $error("speed indicator level wrong for attached port");
    a_bc_state_map: assert property ( // R2
      s.rst_s2 |=> (o_charge_handshake_indicator_oe_n[g] == !$past(i_port[g].bc_enabled))
        && ($past(i_port[g].bc_enabled) ->
            o_charge_handshake_indicator[g] == !$past(i_port[g].bc_done)))
      else $error("charge indicator does not match charge state");
    a_upd_latency_port: assert property ( // R8
      (s.rst_s2 && $changed(i_port[g].attached)) ##1 s.rst_s2 |->
        ##[0:1] (o_port_speed_indicator_oe_n[g] == !$past(i_port[g].attached)))
      else $error("speed indicator slow to follow attach change");
  end

  a_host_level_inv: assert property ( // R3
    (s.rst_s2 && i_host.connected) |=>
      (o_host_speed_indicator_oe_n == 2'h0
       && o_host_speed_indicator == {2{!$past(i_host.super_speed)}}))
    else $error("host speed indicator polarity wrong");
  a_susp_follow_state: assert property ( // R4
    s.rst_s2 |=> o_suspend_state_output == $past(i_suspended))
    else $error("suspend output does not follow suspend state");
  a_reset_mode_held: assert property ( // R5
    pin_low_seq |=> o_reset_mode && o_port_speed_indicator_oe_n == 6'h3f
      && o_charge_handshake_indicator_oe_n == 6'h3f && o_host_speed_indicator_oe_n == 2'h3)
    else $error("reset mode not held or indicators not floating");
  a_mgmt_role_mux: assert property ( // R6
    (s.rst_s2 && o_role_bridge) |=> o_mgmt_bus_clock_pin_oe_n == !$past(i_brg_req.scl_low))
    else $error("bridge role does not own the clock wire");
  a_strap_latch_rise: assert property ( // R7
    pin_release_seq |=> o_role_bridge == $past(s.strap_s2))
    else $error("strap not latched at reset release");
  a_strap_hold_idle: assert property ( // R7
    (!(s.rst_s2 && !s.rst_prev) && s.por_cnt == hpsi_pkg::POR_DONE) |=> $stable(o_role_bridge))
    else $error("latched strap changed without a reset event");

endmodule : hpsi_top

// file: test/hpsi_board_model.sv
module hpsi_board_model (
  input wire logic i_scl_oe_n, // dut pulls clock wire low
  input wire logic i_sda_oe_n, // dut pulls data wire low
  input wire logic i_far_scl_low, // far side stretches clock
  input wire logic i_far_sda_low, // far side pulls data low
  output logic o_scl, // resolved clock wire
  output logic o_sda // resolved data wire
);
  timeunit 1ns;
  timeprecision 1ns;
  // open drain with pull-up: a released wire reads high, any low wins
  assign o_scl = !(!i_scl_oe_n || i_far_scl_low);
  assign o_sda = !(!i_sda_oe_n || i_far_sda_low);
endmodule : hpsi_board_model

// file: test/hub_port_status_indicators_tb_top.sv
module hub_port_status_indicators_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed
  {
    hpsi_pkg::hpsi_port_t p;
    hpsi_pkg::hpsi_host_t h;
    logic s;
    logic [6:0] e; // spd, spd_oe_n, bc, bc_oe_n, host, host_oe_n, susp
  } hpsi_row_t;
  hpsi_row_t rows [5] = '{'{4'h0, 2'h0, 1'h0, 7'h2a}, '{4'h8, 2'h2, 1'h1, 7'h0d},
    '{4'he, 2'h3, 1'h0, 7'h50}, '{4'hb, 2'h1, 1'h1, 7'h03}, '{4'h5, 2'h0, 1'h0, 7'h2a}};
  logic clk = 1'h0, nrst = 1'h0, pin_n = 1'h0, strap = 1'h0, susp = 1'h0;
  logic far_scl = 1'h0, far_sda = 1'h0, scl, sda, scl_oe_n, sda_oe_n;
  hpsi_pkg::hpsi_port_t [5:0] port = '0;
  hpsi_pkg::hpsi_host_t host = '0;
  hpsi_pkg::hpsi_wire_req_t tgt = '0, brg = '0;
  logic [5:0] spd, spd_oe, bc, bc_oe;
  logic [1:0] hs, hs_oe;
  logic o_susp, scl_s, sda_s, role, rmode, scl_o, sda_o;
  int n_mismatch = 0, tests_run = 0, cyc = 0;
  hpsi_top dut (.i_clk_sys(clk), .i_nrst(nrst), .i_rst_pin_n(pin_n), .i_cfg_strap(strap),
    .i_port(port), .i_host(host), .i_suspended(susp), .i_tgt_req(tgt), .i_brg_req(brg),
    .i_mgmt_bus_clock_pin(scl), .i_mgmt_bus_data_pin(sda), .o_port_speed_indicator(spd),
    .o_port_speed_indicator_oe_n(spd_oe), .o_charge_handshake_indicator(bc),
    .o_charge_handshake_indicator_oe_n(bc_oe), .o_host_speed_indicator(hs),
    .o_host_speed_indicator_oe_n(hs_oe), .o_suspend_state_output(o_susp),
    .o_mgmt_bus_clock_pin(scl_o), .o_mgmt_bus_clock_pin_oe_n(scl_oe_n),
    .o_mgmt_bus_data_pin(sda_o),
    .o_mgmt_bus_data_pin_oe_n(sda_oe_n), .o_mgmt_scl_sync(scl_s), .o_mgmt_sda_sync(sda_s),
    .o_role_bridge(role), .o_reset_mode(rmode));
  hpsi_board_model board (.i_scl_oe_n(scl_oe_n), .i_sda_oe_n(sda_oe_n),
    .i_far_scl_low(far_scl), .i_far_sda_low(far_sda), .o_scl(scl), .o_sda(sda));
  initial
  begin
    forever #50 clk = ~clk;
  end
  task automatic summarize();
    if (n_mismatch == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (exp !== got)
    begin
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
      n_mismatch++;
    end
  endtask : chk
  task automatic edges(input int n);
    repeat (n) @(negedge clk);
  endtask : edges
  // floated value bits read as one so only driven levels count
  task automatic chk_ind(input logic [6:0] e);
    chk(16'({spd_oe, spd | spd_oe}), 16'({{6{e[5]}}, {6{e[6] | e[5]}}}));
    chk(16'({bc_oe, bc | bc_oe}), 16'({{6{e[3]}}, {6{e[4] | e[3]}}}));
    chk(16'({hs_oe, hs | hs_oe}), 16'({{2{e[1]}}, {2{e[2] | e[1]}}}));
    chk(16'(o_susp), 16'(e[0]));
  endtask : chk_ind
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_mismatch++;
      summarize();
    end
  end
  initial
  begin
    edges(8);
    nrst = 1'h1;
    pin_n = 1'h1;
    edges(2);
    chk(16'({rmode, spd_oe, bc_oe}), 16'h1fff);
    edges(3);
    chk(16'({rmode, role}), 16'h0);
    foreach (rows[i])
    begin
      port = {6{rows[i].p}};
      host = rows[i].h;
      susp = rows[i].s;
      edges(1);
      chk_ind(rows[i].e);
    end
    // one port alone shows up only on its own bit
    port = '0;
    port[2] = 4'hc;
    edges(1);
    chk({2'h0, spd_oe, 2'h0, spd}, 16'h3b04);
    // target role: bridge requests are ignored
    tgt.sda_low = 1'h1;
    brg.scl_low = 1'h1;
    far_scl = 1'h1;
    edges(1);
    chk(16'({scl_oe_n, sda_oe_n}), 16'h2);
    chk(16'({scl_o, sda_o}), 16'h0);
    edges(3);
    chk(16'({scl_s, sda_s}), 16'h0);
    far_scl = 1'h0;
    // after power-on the strap is only taken when the reset pin rises
    strap = 1'h1;
    pin_n = 1'h0;
    edges(4);
    chk(16'({rmode, role, scl_oe_n, sda_oe_n, spd_oe}), 16'h02ff);
    pin_n = 1'h1;
    edges(6);
    strap = 1'h0;
    edges(2);
    chk(16'({rmode, role, scl_oe_n, sda_oe_n}), 16'h5);
    chk({2'h0, spd_oe, 2'h0, spd}, 16'h3b04);
    summarize();
  end
endmodule : hub_port_status_indicators_tb_top
